// >>> core/msre_pkg.sv
// Constants and types for the motion status reply encoder
`default_nettype none
package msre_pkg;
  // Host link and reply framing
  localparam logic [31:0] MSRE_REQ_WORD    = 32'h73746567; // Status request command word
  localparam int          MSRE_WORD_BYTES  = 4;
  localparam int          MSRE_REPLY_BYTES = 8;
  localparam logic [1:0]  MSRE_LAST_RX     = 2'h3;
  localparam logic [2:0]  MSRE_LAST_ECHO   = 3'h3;
  localparam logic [2:0]  MSRE_LAST_TX     = 3'h7;

  // Move state byte bits
  localparam int MSRE_MS_MOVING   = 0;
  localparam int MSRE_MS_TARGET   = 1;
  localparam int MSRE_MS_BACKLASH = 2;

  // Motion command state byte
  localparam logic [7:0] MSRE_COMMAND_CODE_MASK = 8'h3f;
  localparam int         MSRE_COMMAND_FAILED_BIT    = 6;
  localparam int         MSRE_COMMAND_EXECUTING_BIT = 7;
  localparam logic [5:0] MSRE_CODE_UNKNOWN      = 6'h00;
  localparam logic [5:0] MSRE_CODE_SOFT_STOP    = 6'h08;

  // Winding power state codes
  localparam logic [7:0] MSRE_POWER_UNKNOWN          = 8'h00;
  localparam logic [7:0] MSRE_WINDINGS_DISCONNECTED  = 8'h01;
  localparam logic [7:0] MSRE_NOMINAL_CURRENT        = 8'h03;
  localparam logic [7:0] MSRE_REDUCED_CURRENT        = 8'h04;
  localparam logic [7:0] MSRE_MAXIMUM_CURRENT        = 8'h05;

  // Encoder state codes
  localparam logic [7:0] MSRE_ENCODER_ABSENT   = 8'h00;
  localparam logic [7:0] MSRE_ENCODER_UNKNOWN  = 8'h01;
  localparam logic [7:0] MSRE_ENCODER_FAULTY   = 8'h02;
  localparam logic [7:0] MSRE_ENCODER_REVERSED = 8'h03;
  localparam logic [7:0] MSRE_ENCODER_GOOD     = 8'h04;

  // Register offsets (byte addresses) and reset values
  localparam logic [7:0]  MSRE_REG_CTRL     = 8'h00;
  localparam logic [7:0]  MSRE_REG_LIVE     = 8'h04;
  localparam logic [7:0]  MSRE_REG_INT_STAT = 8'h08;
  localparam logic [7:0]  MSRE_REG_INT_MASK = 8'h0c;
  localparam logic [7:0]  MSRE_REG_REQ_CNT  = 8'h10;
  localparam logic        MSRE_CTRL_RESET   = 1'h1;
  localparam int          MSRE_EV_W         = 4;
  localparam logic [3:0]  MSRE_MASK_RESET   = 4'h0;

  // Interrupt event positions
  localparam int MSRE_EV_REQUEST  = 0;
  localparam int MSRE_EV_CMD_OK   = 1;
  localparam int MSRE_EV_CMD_FAIL = 2;
  localparam int MSRE_EV_BAD_REQ  = 3;

  // Power mode selector from the driver stage
  typedef enum logic [1:0] {
    MSRE_PWR_OFF     = 2'h0,
    MSRE_PWR_NOMINAL = 2'h1,
    MSRE_PWR_REDUCED = 2'h2,
    MSRE_PWR_MAX     = 2'h3
  } msre_pwr_t;

  // Reply state machine, Gray along idle -> echo -> status
  typedef enum logic [1:0] {
    MSRE_S_IDLE = 2'h0,
    MSRE_S_ECHO = 2'h1,
    MSRE_S_STAT = 2'h3
  } msre_state_t;
endpackage
`default_nettype wire

// >>> core/msre_top.sv
// Status request decoder and status reply byte encoder
//
// Function
// - Only the four-byte status word is a request, and it is answered with the status reply.
// - Move state bit 0x01 is set while the motor is actively driven and clear otherwise.
// - Move state bit 0x02 is set once the target speed is reached.
// - Move state bit 0x04 is set while a backlash compensation motion runs.
// - The low six command bits hold the current or last motion command code, 0x00 to 0x08.
// - Command bit 0x80 is one while a motion command executes and clears when it ends.
// - Command bit 0x40 records whether the finished command ended in error.
// - Winding power is reported as 0x01 off, 0x03 nominal, 0x04 reduced, 0x05 maximum.
// - Winding power code 0x00 is never reported.
// - Encoder state is 0x00 absent, 0x01 unknown, 0x02 faulty.
// - Encoder state is 0x03 when counting reversed and 0x04 when working properly.
`default_nettype none
module msre_top
  import msre_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  output logic             rx_ready_out,
  output logic             tx_valid_out,
  output logic [7:0]       tx_data_out,
  input  wire logic        tx_ready_in,
  input  wire logic        moving_in,
  input  wire logic        target_speed_in,
  input  wire logic        backlash_in,
  input  wire logic        cmd_start_in,
  input  wire logic [5:0]  cmd_code_in,
  input  wire logic        cmd_done_in,
  input  wire logic        cmd_error_in,
  input  wire logic [1:0]  power_mode_in,
  input  wire logic        enc_present_in,
  input  wire logic        enc_known_in,
  input  wire logic        enc_fault_in,
  input  wire logic        enc_reversed_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  output logic             irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  msre_state_t          state_q, state_d;
  logic [1:0]           rx_cnt_q;
  logic [23:0]          rx_word_q;
  logic [2:0]           tx_idx_q;
  logic                 tx_valid_q;
  logic [7:0]           tx_data_q;
  logic [63:0]          snap_q;
  logic [5:0]           cmd_code_q;
  logic                 cmd_run_q;
  logic                 cmd_err_q;
  logic                 ctrl_en_q;
  logic [MSRE_EV_W-1:0] int_stat_q;
  logic [MSRE_EV_W-1:0] int_mask_q;
  logic [15:0]          req_cnt_q;
  logic [31:0]          rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Live status bytes, built from the motion engine's levels and the registered command state
  logic [7:0] move_state_byte;
  logic [7:0] motion_command_state_byte;
  logic [7:0] winding_power_state;
  logic [7:0] encoder_state_byte;
  logic [5:0] code_in_range;

  assign move_state_byte = {5'h00, backlash_in, target_speed_in, moving_in};
  // Codes outside the documented set are reported as unknown
  assign code_in_range = (cmd_code_in > MSRE_CODE_SOFT_STOP) ? MSRE_CODE_UNKNOWN
                                                              : cmd_code_in;
  assign motion_command_state_byte = {cmd_run_q, cmd_err_q, cmd_code_q};
  // Every mode maps to a defined code, so the unknown code cannot appear
  assign winding_power_state =
      (msre_pwr_t'(power_mode_in) == MSRE_PWR_OFF)     ? MSRE_WINDINGS_DISCONNECTED :
      (msre_pwr_t'(power_mode_in) == MSRE_PWR_NOMINAL) ? MSRE_NOMINAL_CURRENT       :
      (msre_pwr_t'(power_mode_in) == MSRE_PWR_REDUCED) ? MSRE_REDUCED_CURRENT       :
                                                         MSRE_MAXIMUM_CURRENT;
  // Presence first, then knowledge, then fault, then direction
  assign encoder_state_byte =
      !enc_present_in ? MSRE_ENCODER_ABSENT   :
      !enc_known_in   ? MSRE_ENCODER_UNKNOWN  :
      enc_fault_in    ? MSRE_ENCODER_FAULTY   :
      enc_reversed_in ? MSRE_ENCODER_REVERSED :
                        MSRE_ENCODER_GOOD;

  ////////////////////////////////////////////////////////////////////////////
  // Request framing: bytes arrive low byte first, four to a word
  logic        rx_take;
  logic        rx_last;
  logic [31:0] rx_word;
  logic        req_ok;
  logic        req_bad;

  assign rx_ready_out = (state_q == MSRE_S_IDLE); // Refused while a reply drains
  assign rx_take      = rx_valid_in && rx_ready_out;
  assign rx_last      = rx_take && (rx_cnt_q == MSRE_LAST_RX);
  assign rx_word      = {rx_data_in, rx_word_q};
  assign req_ok       = rx_last && (rx_word == MSRE_REQ_WORD) && ctrl_en_q;
  assign req_bad      = rx_last && !req_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Reply sequencing
  logic       tx_fire;
  logic       tx_end;
  logic [2:0] tx_next;
  logic [7:0] tx_byte;

  assign tx_fire = tx_valid_q && tx_ready_in;
  assign tx_end  = tx_fire && (tx_idx_q == MSRE_LAST_TX);
  assign tx_next = tx_idx_q + 3'h1;
  assign tx_byte = snap_q[{tx_next, 3'h0} +: 8];

  // Next state: echo bytes first, then the four status bytes
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MSRE_S_IDLE: if (req_ok) state_d = MSRE_S_ECHO;
      MSRE_S_ECHO: if (tx_fire && tx_idx_q == MSRE_LAST_ECHO) state_d = MSRE_S_STAT;
      MSRE_S_STAT: if (tx_end) state_d = MSRE_S_IDLE;
      default:     state_d = MSRE_S_IDLE;
    endcase
  end

  // Receive side registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_cnt_q  <= 2'h0;
      rx_word_q <= 24'h000000;
    end else if (ce_in && rx_take) begin
      rx_cnt_q  <= rx_cnt_q + 2'h1;
      rx_word_q <= rx_word[31:8];
    end
  end

  // Snapshot at acceptance keeps every reply byte from one instant
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      snap_q <= 64'h0000000000000000;
    end else if (ce_in && req_ok) begin
      snap_q <= {encoder_state_byte, winding_power_state,
                 motion_command_state_byte, move_state_byte, rx_word};
    end
  end

  // Transmit side registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q    <= MSRE_S_IDLE;
      tx_valid_q <= 1'h0;
      tx_data_q  <= 8'h00;
      tx_idx_q   <= 3'h0;
    end else if (ce_in) begin
      state_q <= state_d;
      if (req_ok) begin
        tx_valid_q <= 1'h1;
        tx_data_q  <= rx_word[7:0];
        tx_idx_q   <= 3'h0;
      end else if (tx_end) begin
        tx_valid_q <= 1'h0;
      end else if (tx_fire) begin
        tx_data_q <= tx_byte;
        tx_idx_q  <= tx_next;
      end
    end
  end

  assign tx_valid_out = tx_valid_q;
  assign tx_data_out  = tx_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // Motion command tracking; a new start takes priority over a done
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cmd_code_q <= MSRE_CODE_UNKNOWN;
      cmd_run_q  <= 1'h0;
      cmd_err_q  <= 1'h0;
    end else if (ce_in) begin
      if (cmd_start_in) begin
        cmd_code_q <= code_in_range;
        cmd_run_q  <= 1'h1;
        cmd_err_q  <= 1'h0;
      end else if (cmd_done_in && cmd_run_q) begin
        cmd_run_q <= 1'h0;
        cmd_err_q <= cmd_error_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode and interrupt events
  logic                 wr_ctrl;
  logic                 wr_stat;
  logic                 wr_mask;
  logic [MSRE_EV_W-1:0] events;
  logic [31:0]          rd_mux;
  logic                 cmd_fin;

  assign wr_ctrl = reg_wr_in && (reg_addr_in == MSRE_REG_CTRL);
  assign wr_stat = reg_wr_in && (reg_addr_in == MSRE_REG_INT_STAT);
  assign wr_mask = reg_wr_in && (reg_addr_in == MSRE_REG_INT_MASK);
  assign cmd_fin = cmd_done_in && cmd_run_q && !cmd_start_in;
  assign events  = {req_bad, cmd_fin && cmd_error_in, cmd_fin && !cmd_error_in, req_ok};
  // Unmapped addresses read as zero
  assign rd_mux =
      (reg_addr_in == MSRE_REG_CTRL)     ? {31'h00000000, ctrl_en_q} :
      (reg_addr_in == MSRE_REG_LIVE)     ? {encoder_state_byte, winding_power_state,
                                            motion_command_state_byte, move_state_byte} :
      (reg_addr_in == MSRE_REG_INT_STAT) ? {28'h0000000, int_stat_q} :
      (reg_addr_in == MSRE_REG_INT_MASK) ? {28'h0000000, int_mask_q} :
      (reg_addr_in == MSRE_REG_REQ_CNT)  ? {16'h0000, req_cnt_q} :
                                           32'h00000000;

  // Control, mask and request counter
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_en_q  <= MSRE_CTRL_RESET;
      int_mask_q <= MSRE_MASK_RESET;
      req_cnt_q  <= 16'h0000;
    end else if (ce_in) begin
      if (wr_ctrl) ctrl_en_q <= reg_wdata_in[0];
      if (wr_mask) int_mask_q <= reg_wdata_in[MSRE_EV_W-1:0];
      if (req_ok) req_cnt_q <= req_cnt_q + 16'h0001;
    end
  end

  // Sticky status: a new event beats a write-one clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      int_stat_q <= '0;
    end else if (ce_in) begin
      int_stat_q <= (int_stat_q & ~(wr_stat ? reg_wdata_in[MSRE_EV_W-1:0] : '0)) | events;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_q <= 32'h00000000;
    end else if (ce_in) begin
      rdata_q <= reg_rd_in ? rd_mux : 32'h00000000;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign irq_out       = |(int_stat_q & int_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_accept;
    req_ok;
  endsequence
  // Reply drained: no byte offered and the request side open again
  sequence s_drained;
    !tx_valid_out && rx_ready_out;
  endsequence

  property p_reply_opens;
    @(posedge clk_in) disable iff (reset_in || !ce_in)
      s_accept |=> tx_valid_out && (tx_data_out == $past(rx_word[7:0])) && !rx_ready_out;
  endproperty
  a_reply_opens: assert property (p_reply_opens) else $error("Reply lacks echo");

  property p_status_order;
    @(posedge clk_in) disable iff (reset_in || !ce_in)
      tx_fire && tx_idx_q == MSRE_LAST_ECHO |=> tx_data_out == snap_q[39:32];
  endproperty
  a_status_order: assert property (p_status_order) else $error("Move state not after echo");

  property p_bad_ignored;
    @(posedge clk_in) disable iff (reset_in || !ce_in)
      rx_last && rx_word != MSRE_REQ_WORD |=> (!tx_valid_out) [*2];
  endproperty
  a_bad_ignored: assert property (p_bad_ignored) else $error("Non-request word answered");

  property p_move_flags;
    @(posedge clk_in) disable iff (reset_in)
      move_state_byte[MSRE_MS_MOVING] == moving_in &&
      move_state_byte[MSRE_MS_TARGET] == target_speed_in &&
      move_state_byte[MSRE_MS_BACKLASH] == backlash_in;
  endproperty
  a_move_flags: assert property (p_move_flags) else $error("Move flags wrong");

  property p_cmd_code;
    @(posedge clk_in) disable iff (reset_in || !ce_in)
      cmd_start_in && cmd_code_in <= MSRE_CODE_SOFT_STOP |=>
        (motion_command_state_byte & MSRE_COMMAND_CODE_MASK) == {2'h0, $past(cmd_code_in)};
  endproperty
  a_cmd_code: assert property (p_cmd_code) else $error("Command code not held");

  property p_running;
    @(posedge clk_in) disable iff (reset_in || !ce_in)
      cmd_start_in || (cmd_run_q && !cmd_done_in) |=>
        motion_command_state_byte[MSRE_COMMAND_EXECUTING_BIT];
  endproperty
  a_running: assert property (p_running) else $error("Running bit dropped early");

  property p_finish_error;
    @(posedge clk_in) disable iff (reset_in || !ce_in)
      cmd_fin |=> !motion_command_state_byte[MSRE_COMMAND_EXECUTING_BIT] &&
        motion_command_state_byte[MSRE_COMMAND_FAILED_BIT] == $past(cmd_error_in);
  endproperty
  a_finish_error: assert property (p_finish_error) else $error("Finish state wrong");

  property p_power_codes;
    @(posedge clk_in) disable iff (reset_in)
      winding_power_state != MSRE_POWER_UNKNOWN &&
      (msre_pwr_t'(power_mode_in) == MSRE_PWR_MAX) ==
        (winding_power_state == MSRE_MAXIMUM_CURRENT);
  endproperty
  a_power_codes: assert property (p_power_codes) else $error("Power state code wrong");

  property p_encoder_codes;
    @(posedge clk_in) disable iff (reset_in)
      (!enc_present_in |-> encoder_state_byte == MSRE_ENCODER_ABSENT) and
      (enc_present_in && enc_known_in && !enc_fault_in && !enc_reversed_in
        |-> encoder_state_byte == MSRE_ENCODER_GOOD);
  endproperty
  a_encoder_codes: assert property (p_encoder_codes) else $error("Encoder code wrong");

  property p_reply_length;
    @(posedge clk_in) disable iff (reset_in || !ce_in)
      tx_end |=> s_drained;
  endproperty
  a_reply_length: assert property (p_reply_length) else $error("Reply not ended");
endmodule
`default_nettype wire

// >>> testbench/msre_host.sv
// Host model: sends request words and collects status replies
`default_nettype none
module msre_host (
  input  wire logic       clk_in,
  input  wire logic       rx_ready_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            rx_valid_out,
  output logic [7:0]      rx_data_out,
  output logic            tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int to_cnt = 0;
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out  = 8'h00;
    tx_ready_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Word goes low byte first; each byte is held until the device takes it
  task automatic send_word(input logic [31:0] w);
    int n;
    for (int b = 0; b < 4; b++) begin
      rx_valid_out <= 1'b1;
      rx_data_out  <= w[8*b +: 8];
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (!rx_ready_in && n < 100);
      if (n >= 100) to_cnt++;
    end
    // Released line shows the inverse so a stale byte cannot pass
    rx_valid_out <= 1'b0;
    rx_data_out  <= ~w[31:24];
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Collect eight reply bytes in arrival order, stalling before each
  task automatic get_reply(input int stall, output logic [63:0] r);
    int n;
    r = 64'h0;
    for (int b = 0; b < 8; b++) begin
      if (stall > 0) begin
        tx_ready_out <= 1'b0;
        repeat (stall) @(posedge clk_in);
      end
      tx_ready_out <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (!tx_valid_in && n < 100);
      if (n >= 100) to_cnt++;
      r[8*b +: 8] = tx_data_in;
    end
    tx_ready_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> testbench/msre_top_tb.sv
// Self-checking bench for the motion status reply encoder
`default_nettype none
module msre_top_tb;
  import msre_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, reset_in, ce, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0]  rx_data, tx_data, reg_addr;
  logic        moving, tgt, blash, cmd_start, cmd_done, cmd_err;
  logic [5:0]  cmd_code, m_code;
  logic [1:0]  pwr;
  logic        enc_p, enc_k, enc_f, enc_r, reg_wr, reg_rd, irq, m_run, m_err;
  logic [31:0] reg_wdata, reg_rdata, seed, r, d;
  logic [63:0] rep;
  int          n_errors = 0;
  int          checks = 0;
  msre_top u_msre_top (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce),
    .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_ready_out(rx_ready),
    .tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_ready_in(tx_ready),
    .moving_in(moving), .target_speed_in(tgt), .backlash_in(blash),
    .cmd_start_in(cmd_start), .cmd_code_in(cmd_code), .cmd_done_in(cmd_done),
    .cmd_error_in(cmd_err), .power_mode_in(pwr), .enc_present_in(enc_p),
    .enc_known_in(enc_k), .enc_fault_in(enc_f), .enc_reversed_in(enc_r),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .irq_out(irq));
  msre_host u_msre_host (.clk_in(clk_in), .rx_ready_in(rx_ready), .tx_valid_in(tx_valid),
    .tx_data_in(tx_data), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
    .tx_ready_out(tx_ready));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, and xorshift stream for repeatable stimulus
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Register bus: one-cycle strobes, read data only in the next cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    @(posedge clk_in);
    v = reg_rdata;
  endtask
  // Expected status bytes {encoder, power, command, move} from the inputs
  function automatic logic [31:0] exp_live();
    logic [7:0] e;
    logic [7:0] p;
    e = !enc_p ? 8'h00 : !enc_k ? 8'h01 : enc_f ? 8'h02 : enc_r ? 8'h03 : 8'h04;
    p = pwr == 2'h0 ? 8'h01 : pwr == 2'h1 ? 8'h03 : pwr == 2'h2 ? 8'h04 : 8'h05;
    return {e, p, m_run, m_err, m_code, 5'h00, blash, tgt, moving};
  endfunction
  task automatic finish_test();
    n_errors += u_msre_host.to_cnt;
    $display("Checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'h0000004b;
    ce = 1'b1;
    {reset_in, reg_wr, reg_rd, cmd_start, cmd_done, cmd_err} = 6'h20;
    {moving, tgt, blash, enc_p, enc_k, enc_f, enc_r} = 7'h00;
    {reg_addr, reg_wdata, cmd_code, pwr} = '0;
    {m_run, m_err, m_code} = '0;
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    chk({rx_ready, tx_valid, irq}, 3'h4);
    rd(MSRE_REG_CTRL, d);
    chk(d, 32'h1);
    rd(MSRE_REG_INT_MASK, d);
    chk(d, 32'h0);
    rd(8'h14, d);
    chk(d, 32'h0);
    wr(MSRE_REG_LIVE, 32'hffffffff);
    // Every command code, power mode and encoder state, with host stalls
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      moving   <= r[0];
      tgt      <= r[1];
      blash    <= r[2];
      pwr      <= 2'(i);
      enc_p    <= (i % 5) != 0;
      enc_k    <= (i % 5) != 1;
      enc_f    <= (i % 5) == 2;
      enc_r    <= (i % 5) == 3;
      cmd_code <= 6'(i);
      cmd_start <= 1'b1;
      @(posedge clk_in);
      cmd_start <= 1'b0;
      m_code = i > 8 ? 6'h00 : 6'(i);
      m_run = 1'b1;
      m_err = 1'b0;
      if (i % 2 == 1) begin
        cmd_done <= 1'b1;
        cmd_err  <= r[9];
        @(posedge clk_in);
        cmd_done <= 1'b0;
        m_run = 1'b0;
        m_err = r[9];
      end
      @(posedge clk_in);
      u_msre_host.send_word(MSRE_REQ_WORD);
      u_msre_host.get_reply(i % 3, rep);
      chk(rep, {exp_live(), MSRE_REQ_WORD});
      rd(MSRE_REG_LIVE, d);
      chk(d, exp_live());
      if (u_msre_host.to_cnt != 0) finish_test();
    end
    // Every one of the ten requests was counted
    rd(MSRE_REG_REQ_CNT, d);
    chk(d, 32'ha);
    // Wrong word: no reply, bad-word event raises the interrupt when unmasked
    wr(MSRE_REG_INT_STAT, 32'hf);
    u_msre_host.send_word(32'h12345678);
    repeat (4) @(posedge clk_in);
    chk(tx_valid, 1'b0);
    rd(MSRE_REG_INT_STAT, d);
    chk(d, 32'h8);
    chk(irq, 1'b0);
    wr(MSRE_REG_INT_MASK, 32'h8);
    repeat (2) @(posedge clk_in);
    chk(irq, 1'b1);
    wr(MSRE_REG_INT_STAT, 32'h8);
    repeat (2) @(posedge clk_in);
    chk(irq, 1'b0);
    // Clock enable low freezes state, so this mask write is lost
    ce <= 1'b0;
    wr(MSRE_REG_INT_MASK, 32'h0);
    ce <= 1'b1;
    rd(MSRE_REG_INT_MASK, d);
    chk(d, 32'h8);
    // Replies disabled: the status word goes unanswered
    wr(MSRE_REG_CTRL, 32'h0);
    u_msre_host.send_word(MSRE_REQ_WORD);
    repeat (4) @(posedge clk_in);
    chk({tx_valid, rx_ready, irq}, 3'h3);
    // Mid-run reset brings back power-on values and a working reply path
    reset_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    {m_run, m_err, m_code} = '0;
    @(posedge clk_in);
    chk({rx_ready, tx_valid, irq}, 3'h4);
    rd(MSRE_REG_CTRL, d);
    chk(d, 32'h1);
    rd(MSRE_REG_REQ_CNT, d);
    chk(d, 32'h0);
    u_msre_host.send_word(MSRE_REQ_WORD);
    u_msre_host.get_reply(1, rep);
    chk(rep, {exp_live(), MSRE_REQ_WORD});
    rd(MSRE_REG_REQ_CNT, d);
    chk(d, 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
